// [core/srac_regs.svh]
// Purpose: Constants of the serial register access command block
// Assumes: 20 MHz core clock
// Notes:   Offsets are bit positions; masks select register fields
`ifndef SRAC_REGS_SVH
`define SRAC_REGS_SVH

// Opcodes
`define SRAC_OP_RD_SR1     8'h05
`define SRAC_OP_RD_SR2     8'h07
`define SRAC_OP_RD_CFG     8'h35
`define SRAC_OP_BANK_RD    8'h16
`define SRAC_OP_BANK_WR    8'h17
`define SRAC_OP_BANK_OPEN  8'hb9
`define SRAC_OP_WRR        8'h01
`define SRAC_OP_WRITE_ENABLE_CMD       8'h06

// Status register 1 bit positions
`define SRAC_SR1_WIP       0
`define SRAC_SR1_WEL       1
`define SRAC_SR1_E_ERR     5
`define SRAC_SR1_P_ERR     6
`define SRAC_SR1_STATUS_WRITE_DISABLE      7
// Configuration register bit positions
`define SRAC_CR_QUAD       1
// Bank register bit position of the four-byte address enable
`define SRAC_BAR_EXT       7

// Writable, one-time and nonvolatile field masks
`define SRAC_SR1_WMASK     8'h9c
`define SRAC_SR1_NV        8'h9c
`define SRAC_CR_WMASK      8'hef
`define SRAC_CR_OTP        8'h2c
`define SRAC_CR_NV         8'hee
`define SRAC_SR2_WMASK     8'h60
`define SRAC_SR2_NV        8'h00
`define SRAC_BAR_MASK      8'h83

// Reset values
`define SRAC_SR1_RST       8'h00
`define SRAC_SR2_RST       8'h00
`define SRAC_CR_RST        8'h00
`define SRAC_BAR_RST       8'h00

// Frame lengths in bits, opcode included
`define SRAC_LEN_OP        6'd8
`define SRAC_LEN_1B        6'd16
`define SRAC_LEN_2B        6'd24
`define SRAC_LEN_3B        6'd32

// Timing
`define SRAC_CLK_MHZ       20
`define SRAC_T_W_US        100
`define SRAC_T_W_CYC       (`SRAC_T_W_US * `SRAC_CLK_MHZ)
`define SRAC_T_VOL_CYC     1

`endif

// [core/srac_pkg.sv]
// Purpose: Types of the serial register access command block
// Assumes: Constants come from srac_regs.svh
// Notes:   One struct per clock edge (sck rise, sck fall, clk) holds the state
package srac_pkg;
  typedef logic [7:0]  srac_byte_t;   // One register byte
  typedef logic [1:0]  srac_bank_t;   // Address bits above A23
  typedef logic [11:0] srac_wcnt_t;   // Write timer

  // State at the link, clocked by the serial clock
  typedef struct packed {
    logic [5:0]  cnt;       // Bits seen in this frame
    logic        over;      // More than 32 bits seen
    srac_byte_t  op;        // Opcode
    logic        op_valid;  // Opcode complete
    logic [23:0] dat;       // Last data bits
  } srac_link_t;

  // Read data launch, clocked on the falling serial edge
  typedef struct packed {
    srac_byte_t obyte;      // Byte being shifted out
    logic       so;         // Serial output
    logic       so_oe;      // Output enable
  } srac_out_t;

  // Register state in the core clock domain
  typedef struct packed {
    srac_byte_t sr1;        // Status register 1
    srac_byte_t sr2;        // Status register 2
    srac_byte_t cr;         // Configuration register
    srac_byte_t bar;        // Bank address register
    srac_byte_t p_sr1;      // Pending status 1 value
    srac_byte_t p_cr;       // Pending configuration value
    srac_byte_t p_sr2;      // Pending status 2 value
    logic       cs_q;       // Previous synchronised select
    logic       bank_access_open_cmd;       // Bank access window open
    logic       busy;       // Self-timed write running
    logic       nv;         // Running write touches nonvolatile bits
    srac_wcnt_t wcnt;       // Cycles left in the write
    srac_bank_t addr_hi;    // Upper address for 3-byte commands
    logic       ext;        // Four-byte address enable copy
  } srac_core_t;
endpackage

// [core/srac_sync.sv]
// Purpose: Two flip-flop level synchroniser
// Assumes: Each bit is an independent level
// Notes:   The first stage is read only by the second
module srac_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;  // First stage, may be metastable

  // Plain pipeline; no reset needed, it flushes in two edges
  always_ff @(posedge clk) begin
    meta <= d;
    q    <= meta;
  end
endmodule

// [core/srac_reg_access.sv]
// Purpose: Register access commands of a serial flash, device side
// Assumes: SPI mode 0 or 3; select high time of at least four clk
// Notes:   Link logic runs on sck; frame results cross at select rise
//
// Functional notes
// - 05h streams status 1, refreshed per byte
// - 07h streams status 2, refreshed per byte
// - 35h streams configuration, even while busy
// - 16h streams bank register repeatedly
// - 17h loads bank register, no enable needed
// - Upper address from bank when extension off
// - Bank write keeps error and busy flags
// - B9h then 01h loads bank bits 1:0
// - That sequence ignores rest, keeps extension bit
// - Other command or frame closes bank access
// - 01h needs write enable latch set
// - Failed register write sets error flag
// - Read-only kept, one-time bits never clear
// - 8, 16 or 24 data bits select registers
// - Write busy from select rise to completion
// - Volatile-only write ends at once, else long
// - Write completion clears write enable latch
// - Writes allowed unless disable bit and pin low
// - Disable bit with pin low rejects writes
// - 06h sets write enable latch
// - Quad mode turns hardware protection off
`include "srac_regs.svh"
module srac_reg_access (
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic               sck,
  input  wire logic               cs_b,
  input  wire logic               si,
  input  wire logic               wp_b,
  input  wire logic               nv_write_fail,
  output logic                    so,
  output logic                    so_oe,
  output logic                    write_in_progress,
  output srac_pkg::srac_bank_t    addr_upper,
  output logic                    four_byte_address_enable
);
  import srac_pkg::*;

  srac_link_t l;          // Link state
  srac_link_t next_l;     // Next link state
  srac_out_t  o;          // Falling-edge output state
  srac_out_t  next_o;     // Next output state
  srac_core_t r;          // Core state
  srac_core_t next_r;     // Next core state
  logic       fresh;      // Set while select is high
  logic [31:0] snap;      // Registers seen from the sck domain
  logic       cs_s;       // Select in the clk domain
  logic       wp_s;       // Protect pin in the clk domain
  logic       fe;         // Frame end, one clk cycle
  srac_byte_t b0;         // First data byte of the frame
  logic       protect;    // Hardware protection active

  // Picks a data byte from the frame record by frame length
  function automatic srac_byte_t pick(input logic [23:0] d,
                                      input logic [5:0]  n,
                                      input int          k);
    logic [23:0] al;
    al = d;
    case (n)
      `SRAC_LEN_1B: al = {d[7:0], 16'h0000};
      `SRAC_LEN_2B: al = {d[15:0], 8'h00};
      default:      al = d;
    endcase
    pick = al[23-8*k -: 8];
  endfunction

  // Writable bits take the new value; one-time bits never clear
  function automatic srac_byte_t merge(input srac_byte_t old,
                                       input srac_byte_t d,
                                       input srac_byte_t wm,
                                       input srac_byte_t otp);
    merge = ((old & ~wm) | (d & wm)) | (old & otp);
  endfunction

  // Opcodes answered with a repeating register byte
  function automatic logic is_read(input srac_byte_t op);
    is_read = (op == `SRAC_OP_RD_SR1) || (op == `SRAC_OP_RD_SR2) ||
              (op == `SRAC_OP_RD_CFG) || (op == `SRAC_OP_BANK_RD);
  endfunction

  // Marks the first sck edge of a frame; select high presets it
  always_ff @(posedge sck or posedge cs_b) begin
    if (cs_b) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  // Shift opcode then data, MSB first on rising edges
  always_comb begin
    srac_link_t b;
    b = fresh ? '0 : l;                     // New frame starts clean
    next_l     = b;
    next_l.cnt = b.cnt + 6'd1;              // Wraps; low bits pace reads
    if (b.cnt == `SRAC_LEN_3B) begin
      next_l.over = 1'b1;                   // Too long for any write
    end
    if (!b.op_valid) begin
      next_l.op = {b.op[6:0], si};
      if (b.cnt == 6'd7) begin
        next_l.op_valid = 1'b1;
      end
    end else begin
      next_l.dat = {b.dat[22:0], si};
    end
  end

  // The record stays put after the frame, as sck is then idle
  always_ff @(posedge sck) begin
    l <= next_l;
  end

  // Register copies for read-out; stale bits flush during the opcode
  srac_sync #(.W(32)) u_snap (
    .clk (sck),
    .d   ({r.sr1, r.sr2, r.cr, r.bar}),
    .q   (snap)
  );

  // Read data: a fresh byte each eight clocks, driven on falling edge
  always_comb begin
    srac_byte_t sel;
    sel    = 8'h00;
    next_o = o;
    case (l.op)
      `SRAC_OP_RD_SR1:  sel = snap[31:24];
      `SRAC_OP_RD_SR2:  sel = snap[23:16];
      `SRAC_OP_RD_CFG:  sel = snap[15:8];
      `SRAC_OP_BANK_RD: sel = snap[7:0];
      default:          sel = 8'h00;
    endcase
    if (!fresh && l.op_valid && is_read(l.op)) begin  // Old record, mode 3
      next_o.so_oe = 1'b1;
      if (l.cnt[2:0] == 3'd0) begin
        next_o.obyte = sel;
        next_o.so    = sel[7];
      end else begin
        next_o.so = o.obyte[~l.cnt[2:0]];
      end
    end else begin
      next_o.so_oe = 1'b0;
      next_o.so    = 1'b0;
    end
  end

  // Output stage; select high releases the line at once
  always_ff @(negedge sck or posedge cs_b) begin
    if (cs_b) begin
      o <= '0;
    end else begin
      o <= next_o;
    end
  end

  srac_sync #(.W(1)) u_cs (
    .clk (clk),
    .d   (cs_b),
    .q   (cs_s)
  );

  srac_sync #(.W(1)) u_wp (
    .clk (clk),
    .d   (wp_b),
    .q   (wp_s)
  );

  // Frame end: the link record is stable from here on
  assign fe = cs_s & ~r.cs_q;
  assign b0 = pick(l.dat, l.cnt, 0);
  // Pin protection only counts outside quad mode
  assign protect = r.sr1[`SRAC_SR1_STATUS_WRITE_DISABLE] & ~wp_s &
                   ~r.cr[`SRAC_CR_QUAD];

  // Command execution at frame end and the self-timed write
  always_comb begin
    logic       len_ok;
    srac_byte_t n1;
    srac_byte_t nc;
    srac_byte_t n2;
    len_ok = 1'b0;
    n1     = r.sr1;
    nc     = r.cr;
    n2     = r.sr2;
    next_r      = r;
    next_r.cs_q = cs_s;
    // Upper address bits follow the bank unless extension is on
    next_r.addr_hi = r.bar[`SRAC_BAR_EXT] ? 2'b00 : r.bar[1:0];
    next_r.ext     = r.bar[`SRAC_BAR_EXT];
    // Running write: count down, then commit
    if (r.busy) begin
      if (r.wcnt == '0) begin
        next_r.busy = 1'b0;
        next_r.sr1  = merge(r.sr1, r.p_sr1, `SRAC_SR1_WMASK, 8'h00);
        next_r.cr   = r.p_cr;
        next_r.sr2  = r.p_sr2;
        next_r.sr1[`SRAC_SR1_WIP] = 1'b0;
        next_r.sr1[`SRAC_SR1_WEL] = 1'b0;
        if (r.nv && nv_write_fail) begin
          next_r.sr1[`SRAC_SR1_P_ERR] = 1'b1;
        end
      end else begin
        next_r.wcnt = r.wcnt - 12'd1;
      end
    end
    if (fe && l.op_valid) begin
      if (r.bank_access_open_cmd) begin
        next_r.bank_access_open_cmd = 1'b0;
      end
      if (r.bank_access_open_cmd && (l.op == `SRAC_OP_WRR)) begin
        // Only bits 1:0 of the first byte land; rest ignored
        if (!l.over && (l.cnt >= `SRAC_LEN_1B)) begin
          next_r.bar[1:0] = b0[1:0];
        end
      end else begin
        case (l.op)
          `SRAC_OP_WRITE_ENABLE_CMD: begin
            if (!r.busy && (l.cnt == `SRAC_LEN_OP) && !l.over) begin
              next_r.sr1[`SRAC_SR1_WEL] = 1'b1;
            end
          end
          `SRAC_OP_BANK_OPEN: begin
            if ((l.cnt == `SRAC_LEN_OP) && !l.over) begin
              next_r.bank_access_open_cmd = 1'b1;
            end
          end
          `SRAC_OP_BANK_WR: begin
            // No latch check; status flags left alone
            if (!l.over && (l.cnt >= `SRAC_LEN_1B)) begin
              next_r.bar = b0 & `SRAC_BAR_MASK;
            end
          end
          `SRAC_OP_WRR: begin
            len_ok = !l.over && ((l.cnt == `SRAC_LEN_1B) ||
                                 (l.cnt == `SRAC_LEN_2B) ||
                                 (l.cnt == `SRAC_LEN_3B));
            n1 = merge(r.sr1, b0, `SRAC_SR1_WMASK, 8'h00);
            if (l.cnt != `SRAC_LEN_1B) begin
              nc = merge(r.cr, pick(l.dat, l.cnt, 1),
                         `SRAC_CR_WMASK, `SRAC_CR_OTP);
            end
            if (l.cnt == `SRAC_LEN_3B) begin
              n2 = merge(r.sr2, pick(l.dat, l.cnt, 2),
                         `SRAC_SR2_WMASK, 8'h00);
            end
            // Needs the latch, no write running, no pin lock
            if (len_ok && !r.busy && r.sr1[`SRAC_SR1_WEL] &&
                !protect) begin
              next_r.busy  = 1'b1;
              next_r.sr1[`SRAC_SR1_WIP] = 1'b1;
              next_r.p_sr1 = n1;
              next_r.p_cr  = nc;
              next_r.p_sr2 = n2;
              next_r.nv = (((n1 ^ r.sr1) & `SRAC_SR1_NV) != 8'h00) ||
                          (((nc ^ r.cr) & `SRAC_CR_NV) != 8'h00) ||
                          (((n2 ^ r.sr2) & `SRAC_SR2_NV) != 8'h00);
              // Volatile-only change ends within the deselect time
              if (next_r.nv) begin
                next_r.wcnt = 12'(`SRAC_T_W_CYC - 1);
              end else begin
                next_r.wcnt = 12'(`SRAC_T_VOL_CYC - 1);
              end
            end
          end
          default: begin
            // Other commands belong to other blocks
          end
        endcase
      end
    end
  end

  // Core register update with synchronous reset
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      r      <= '0;
      r.sr1  <= `SRAC_SR1_RST;
      r.sr2  <= `SRAC_SR2_RST;
      r.cr   <= `SRAC_CR_RST;
      r.bar  <= `SRAC_BAR_RST;
      r.cs_q <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign so                       = o.so;
  assign so_oe                    = o.so_oe;
  assign write_in_progress        = r.sr1[`SRAC_SR1_WIP];
  assign addr_upper               = r.addr_hi;
  assign four_byte_address_enable = r.ext;

  property p_write_enable_cmd;
    @(posedge clk) disable iff (!rst_b)
    fe && l.op_valid && !r.bank_access_open_cmd && (l.op == `SRAC_OP_WRITE_ENABLE_CMD) &&
    (l.cnt == `SRAC_LEN_OP) && !l.over && !r.busy |=> r.sr1[`SRAC_SR1_WEL];
  endproperty
  a_write_enable_cmd: assert property (p_write_enable_cmd)
    else $error("write enable did not set latch");
  property p_wrr_needs_wel;
    @(posedge clk) disable iff (!rst_b)
    fe && l.op_valid && !r.bank_access_open_cmd && (l.op == `SRAC_OP_WRR) &&
    !r.sr1[`SRAC_SR1_WEL] && !r.busy |=> !r.busy;
  endproperty
  a_wrr_needs_wel: assert property (p_wrr_needs_wel)
    else $error("register write started without latch");
  property p_protect;
    @(posedge clk) disable iff (!rst_b)
    fe && l.op_valid && !r.bank_access_open_cmd && (l.op == `SRAC_OP_WRR) &&
    protect && !r.busy |=> !r.busy ##1 $stable(r.sr1[7:2]);
  endproperty
  a_protect: assert property (p_protect)
    else $error("protected register write accepted");
  property p_wip_busy;
    @(posedge clk) disable iff (!rst_b)
    r.busy |-> r.sr1[`SRAC_SR1_WIP];
  endproperty
  a_wip_busy: assert property (p_wip_busy)
    else $error("write running with progress flag low");
  property p_done;
    @(posedge clk) disable iff (!rst_b)
    $fell(r.busy) |-> !r.sr1[`SRAC_SR1_WEL] && !r.sr1[`SRAC_SR1_WIP];
  endproperty
  a_done: assert property (p_done)
    else $error("write end left latch or progress set");
  property p_vol_fast;
    @(posedge clk) disable iff (!rst_b)
    $rose(r.busy) && !r.nv |=> !r.busy;
  endproperty
  a_vol_fast: assert property (p_vol_fast)
    else $error("volatile write took more than one cycle");
  property p_bank_wr;
    @(posedge clk) disable iff (!rst_b)
    fe && l.op_valid && !r.bank_access_open_cmd && (l.op == `SRAC_OP_BANK_WR) &&
    !l.over && (l.cnt >= `SRAC_LEN_1B)
    |=> (r.bar == ($past(b0) & `SRAC_BAR_MASK)) &&
        (r.sr1[6:5] == $past(r.sr1[6:5]));
  endproperty
  a_bank_wr: assert property (p_bank_wr)
    else $error("bank write wrong or touched error flags");
  property p_bank_access_open_cmd_wrr;
    @(posedge clk) disable iff (!rst_b)
    fe && l.op_valid && r.bank_access_open_cmd && (l.op == `SRAC_OP_WRR) &&
    !l.over && (l.cnt >= `SRAC_LEN_1B)
    |=> (r.bar[1:0] == $past(b0[1:0])) && !r.bank_access_open_cmd && !r.busy &&
        (r.bar[7] == $past(r.bar[7]));
  endproperty
  a_bank_access_open_cmd_wrr: assert property (p_bank_access_open_cmd_wrr)
    else $error("bank access write mishandled");
  property p_bank_access_open_cmd_close;
    @(posedge clk) disable iff (!rst_b)
    fe && l.op_valid && r.bank_access_open_cmd && (l.op != `SRAC_OP_BANK_OPEN) |=> !r.bank_access_open_cmd;
  endproperty
  a_bank_access_open_cmd_close: assert property (p_bank_access_open_cmd_close)
    else $error("bank access stayed open");
  property p_upper;
    @(posedge clk) disable iff (!rst_b)
    ##1 1'b1 |-> addr_upper ==
      ($past(r.bar[`SRAC_BAR_EXT]) ? 2'b00 : $past(r.bar[1:0]));
  endproperty
  a_upper: assert property (p_upper)
    else $error("upper address not from bank");
endmodule

// [test/srac_host.sv]
// Purpose: Host SPI controller model driving the register access block
// Assumes: Mode 0, serial clock of 32 ns period, idle low between frames
// Notes:   Serial clock stands still outside frames
module srac_host (
  output logic      sck,
  output logic      cs_b,
  output logic      si,
  input  wire logic so
);
  timeunit 1ns;
  timeprecision 1ps;

  // Deselected and quiet until the first frame; the select rise at 1 ns
  // presets the link's first-edge flag and output stage
  initial begin
    sck  = 1'b0;
    si   = 1'b0;
    #1 cs_b = 1'b1;
  end

  // One frame of n bits, MSB first; read bits are captured on rising edges
  task automatic xfer(input int n, input logic [31:0] tx,
                      output logic [31:0] rx);
    int i;
    rx   = '0;
    cs_b = 1'b0;
    #20;
    for (i = n - 1; i >= 0; i--) begin
      si = tx[i];
      #16 sck = 1'b1;
      rx = {rx[30:0], so};
      #16 sck = 1'b0;
    end
    #20 cs_b = 1'b1;
    // Released line shows no stale value
    si = ~si;
    // Long deselect so the frame result lands before the next frame
    #400;
  endtask
endmodule

// [test/srac_reg_access_test.sv]
// Purpose: Self-checking bench of the register access command block
// Assumes: Host model drives the link; bench drives pins and reset
// Notes:   Each scenario is one task and judges its own results
module srac_reg_access_test;
  timeunit 1ns;
  timeprecision 1ps;
  import srac_pkg::*;

  logic                 clk = 1'b0;
  logic                 rst_b = 1'b0;
  logic                 wp_b = 1'b1;
  logic                 nv_write_fail = 1'b0;
  logic                 sck, cs_b, si, so, so_oe, write_in_progress;
  srac_bank_t           addr_upper;
  logic                 four_byte_address_enable;
  int                   num_errors = 0;
  int                   check_count = 0;
  logic [7:0]           b0, b1;
  int                   cyc;
  logic                 oe_seen;      // Output enable at last sck rise

  // Core clock, 50 ns period
  always #25 clk = ~clk;

  srac_reg_access srac_reg_access_inst (.clk(clk), .rst_b(rst_b),
    .sck(sck), .cs_b(cs_b), .si(si), .wp_b(wp_b),
    .nv_write_fail(nv_write_fail), .so(so), .so_oe(so_oe),
    .write_in_progress(write_in_progress), .addr_upper(addr_upper),
    .four_byte_address_enable(four_byte_address_enable));

  srac_host srac_host_inst (.sck(sck), .cs_b(cs_b), .si(si), .so(so));

  // Output enable as the host sees it on each rising serial edge
  always @(posedge sck) oe_seen <= so_oe;

  // Compare one value and count it
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Print counts and verdict, then stop
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Command frame without read data
  task automatic cmd(input int n, input logic [31:0] tx);
    logic [31:0] rx;
    srac_host_inst.xfer(n, tx, rx);
    check({7'h0, oe_seen}, 8'h00);
  endtask

  // Read command taking two output bytes
  task automatic rd(input logic [7:0] op);
    logic [31:0] rx;
    srac_host_inst.xfer(24, {8'h00, op, 16'h0000}, rx);
    b0 = rx[15:8];
    b1 = rx[7:0];
    check({7'h0, oe_seen}, 8'h01);
    check({7'h0, so_oe}, 8'h00);
  endtask

  // Bounded wait for the self-timed write to finish
  task automatic wait_idle;
    cyc = 0;
    while (write_in_progress !== 1'b0 && cyc < 2200) begin
      @(negedge clk);
      cyc++;
    end
    if (cyc >= 2200) begin
      num_errors++;
      conclude();
    end
  endtask

  // Every register reads zero after reset
  task automatic t_reset;
    logic [7:0] ops [4] = '{8'h05, 8'h07, 8'h35, 8'h16};
    foreach (ops[i]) begin
      rd(ops[i]);
      check(b0, 8'h00);
      check(b1, 8'h00);
    end
    check({7'h0, write_in_progress}, 8'h00);
    $display("t_reset done");
  endtask

  // Direct bank writes, extension bit and upper address
  task automatic t_bank;
    cmd(16, {16'h0, 8'h17, 8'h83});
    check({7'h0, four_byte_address_enable}, 8'h01);
    check({6'h0, addr_upper}, 8'h00);
    rd(8'h16);
    check(b0, 8'h83);
    check(b1, 8'h83);
    cmd(16, {16'h0, 8'h17, 8'h02});
    check({7'h0, four_byte_address_enable}, 8'h00);
    check({6'h0, addr_upper}, 8'h02);
    rd(8'h05);
    check(b0, 8'h00);
    $display("t_bank done");
  endtask

  // Latch needed; volatile three-register write ends at once
  task automatic t_volatile;
    cmd(16, {16'h0, 8'h01, 8'h1c});
    rd(8'h05);
    check(b0, 8'h00);
    cmd(8, {24'h0, 8'h06});
    rd(8'h05);
    check(b0, 8'h02);
    cmd(32, {8'h01, 8'h00, 8'h01, 8'h60});
    check({7'h0, write_in_progress}, 8'h00);
    rd(8'h05);
    check(b0, 8'h00);
    rd(8'h35);
    check(b0, 8'h01);
    rd(8'h07);
    check(b1, 8'h60);
    $display("t_volatile done");
  endtask

  // Nonvolatile write: busy period, status readable while busy
  task automatic t_nv(input logic [7:0] v, input logic [7:0] busy_sr);
    cmd(8, {24'h0, 8'h06});
    cmd(24, {8'h0, 8'h01, v, 8'h01});
    check({7'h0, write_in_progress}, 8'h01);
    rd(8'h05);
    check(b0, busy_sr);
    check(b1, busy_sr);
    wait_idle();
    check({7'h0, cyc > 1900 && cyc <= 2000}, 8'h01);
    rd(8'h05);
    check(b0, v);
    $display("t_nv done");
  endtask

  // Bad length refused; access-then-write loads only the low bank bits
  task automatic t_access;
    cmd(8, {24'h0, 8'h06});
    cmd(20, {12'h0, 8'h01, 8'h00, 4'h0});
    rd(8'h05);
    check(b0, 8'h1e);
    cmd(8, {24'h0, 8'hb9});
    cmd(24, {8'h0, 8'h01, 8'hfd, 8'h55});
    check({6'h0, addr_upper}, 8'h01);
    check({7'h0, four_byte_address_enable}, 8'h00);
    cmd(8, {24'h0, 8'hb9});
    rd(8'h05);
    check(b0, 8'h1e);
    cmd(24, {8'h0, 8'h01, 8'h1c, 8'h01});
    check({6'h0, addr_upper}, 8'h01);
    rd(8'h05);
    check(b0, 8'h1c);
    $display("t_access done");
  endtask

  // Disable bit with protect pin low rejects writes; pin high allows,
  // and so does quad mode, where the pin is a data line
  task automatic t_protect;
    t_nv(8'h9c, 8'h1f);
    @(posedge clk) wp_b <= 1'b0;
    cmd(8, {24'h0, 8'h06});
    cmd(24, {8'h0, 8'h01, 8'h1c, 8'h01});
    check({7'h0, write_in_progress}, 8'h00);
    rd(8'h05);
    check(b0, 8'h9e);
    @(posedge clk) wp_b <= 1'b1;
    cmd(24, {8'h0, 8'h01, 8'h9c, 8'h03});
    wait_idle();
    rd(8'h35);
    check(b0, 8'h03);
    @(posedge clk) wp_b <= 1'b0;
    cmd(8, {24'h0, 8'h06});
    cmd(24, {8'h0, 8'h01, 8'h1c, 8'h01});
    wait_idle();
    rd(8'h05);
    check(b0, 8'h1c);
    rd(8'h35);
    check(b0, 8'h01);
    @(posedge clk) wp_b <= 1'b1;
    $display("t_protect done");
  endtask

  // Failed store sets the error flag; bank write keeps busy
  task automatic t_fail;
    cmd(8, {24'h0, 8'h06});
    cmd(24, {8'h0, 8'h01, 8'h9c, 8'h01});
    cmd(16, {16'h0, 8'h17, 8'h00});
    check({7'h0, write_in_progress}, 8'h01);
    @(posedge clk) nv_write_fail <= 1'b1;
    wait_idle();
    @(posedge clk) nv_write_fail <= 1'b0;
    rd(8'h05);
    check(b0 & 8'h40, 8'h40);
    $display("t_fail done");
  endtask

  // Main sequence: reset for 10 clocks, then every scenario
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    #7;
    t_reset();
    t_bank();
    t_volatile();
    t_nv(8'h1c, 8'h03);
    t_access();
    t_protect();
    t_fail();
    conclude();
  end
endmodule
